// >>> hdl/activity_monitor_counters.sv
// Activity monitor counters with system-register and read-only debug APB access
`timescale 1ns/1ps
`default_nettype none

module activity_monitor_counters #(
  parameter int unsigned RETIRE_W = 3
) (
  // Clock and cold reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Event inputs
  input wire logic const_rate_tick,
  input wire logic [RETIRE_W-1:0] retired_count,
  input wire logic mem_stall_cycle,
  input wire logic [activity_monitor_pkg::NUM_GRP1-1:0] aux_event,
  // System-register access
  input wire activity_monitor_pkg::sysreg_req_t sysreg_req,
  output activity_monitor_pkg::sysreg_rsp_t sysreg_rsp,
  // Debug APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [activity_monitor_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int unsigned N = activity_monitor_pkg::NUM_CNT;
  localparam int unsigned W = activity_monitor_pkg::CNT_W;

  logic [N-1:0][W-1:0] cnt_q;
  logic [N-1:0][W-1:0] inc;
  logic level2_trap_en_q;
  logic level3_trap_en_q;
  activity_monitor_pkg::sysreg_rsp_t rsp_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Increments; no debug authentication input exists to gate them
  always_comb begin
    inc = '0;
    inc[activity_monitor_pkg::SLOT_CORE_CYC] = W'(1);
    inc[activity_monitor_pkg::SLOT_CONST_CYC] = W'(const_rate_tick);
    inc[activity_monitor_pkg::SLOT_RETIRED] = W'(retired_count);
    inc[activity_monitor_pkg::SLOT_MEM_STALL] = W'(mem_stall_cycle);
    for (int k = 0; k < activity_monitor_pkg::NUM_GRP1; k++) begin
      inc[activity_monitor_pkg::NUM_GRP0 + k] = W'(aux_event[k]);
    end
  end

  // Request decode
  logic [4:0] sel;
  logic [4:0] type_idx;
  logic is_cnt;
  logic is_type;
  logic is_aux2;
  logic is_aux3;
  logic below2;
  logic below3;
  logic trap;
  logic cnt_load;

  assign sel = sysreg_req.sel;
  assign type_idx = sel - activity_monitor_pkg::SEL_TYPE_BASE;
  assign is_cnt = sel < 5'(N);
  assign is_type = (sel >= activity_monitor_pkg::SEL_TYPE_BASE) && (type_idx < 5'(N));
  assign is_aux2 = sel == activity_monitor_pkg::SEL_LEVEL2_AUX;
  assign is_aux3 = sel == activity_monitor_pkg::SEL_LEVEL3_AUX;
  assign below2 = sysreg_req.level < activity_monitor_pkg::LEVEL2;
  assign below3 = sysreg_req.level < activity_monitor_pkg::LEVEL3;

  // Trap from each level the enables guard; counter writes only from level 3
  always_comb begin
    trap = 1'b1;
    if (is_cnt || is_type) begin
      trap = (below3 && !level3_trap_en_q) || (below2 && !level2_trap_en_q);
      if (is_cnt && sysreg_req.write && below3) begin
        trap = 1'b1;
      end
    end else if (is_aux2) begin
      trap = below2;
    end else if (is_aux3) begin
      trap = below3;
    end
  end

  assign cnt_load = sysreg_req.valid && sysreg_req.write && is_cnt && !trap;

  // Counters wrap freely; no overflow flag or interrupt is kept
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (cnt_load && sel == 5'(i)) begin
          cnt_q[i] <= sysreg_req.wdata;
        end else begin
          cnt_q[i] <= cnt_q[i] + inc[i];
        end
      end
    end
  end

  // Auxiliary control enables; APB never reaches them
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level2_trap_en_q <= activity_monitor_pkg::TRAP_EN_RESET;
      level3_trap_en_q <= activity_monitor_pkg::TRAP_EN_RESET;
    end else if (sysreg_req.valid && sysreg_req.write && !trap) begin
      if (is_aux2) begin
        level2_trap_en_q <= sysreg_req.wdata[activity_monitor_pkg::TRAP_EN_BIT];
      end
      if (is_aux3) begin
        level3_trap_en_q <= sysreg_req.wdata[activity_monitor_pkg::TRAP_EN_BIT];
      end
    end
  end

  // System-register answer one cycle after the request; 64-bit state only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_q <= '0;
    end else begin
      rsp_q.done <= sysreg_req.valid;
      rsp_q.trap <= sysreg_req.valid && trap;
      rsp_q.rdata <= '0;
      if (sysreg_req.valid && !trap && !sysreg_req.write) begin
        if (is_cnt) begin
          rsp_q.rdata <= cnt_q[sel[2:0]];
        end else if (is_type) begin
          rsp_q.rdata <= W'(activity_monitor_pkg::EVENT_CODE[type_idx[2:0]]);
        end else if (is_aux2) begin
          rsp_q.rdata[activity_monitor_pkg::TRAP_EN_BIT] <= level2_trap_en_q;
        end else if (is_aux3) begin
          rsp_q.rdata[activity_monitor_pkg::TRAP_EN_BIT] <= level3_trap_en_q;
        end
      end
    end
  end

  // APB decode
  logic [11:0] cnt_off;
  logic [11:0] type_off;
  logic apb_setup;
  logic [31:0] apb_word;
  logic apb_hit;

  assign cnt_off = paddr - activity_monitor_pkg::APB_CNT_BASE;
  assign type_off = paddr - activity_monitor_pkg::APB_TYPE_BASE;
  assign apb_setup = psel && !penable;

  always_comb begin
    apb_word = '0;
    apb_hit = 1'b0;
    if (paddr[1:0] == 2'h0 && cnt_off < activity_monitor_pkg::APB_CNT_SPAN) begin
      apb_hit = 1'b1;
      apb_word = cnt_off[2] ? cnt_q[cnt_off[5:3]][63:32] : cnt_q[cnt_off[5:3]][31:0];
    end else if (paddr[1:0] == 2'h0 && type_off < activity_monitor_pkg::APB_TYPE_SPAN) begin
      apb_hit = 1'b1;
      apb_word = 32'(activity_monitor_pkg::EVENT_CODE[type_off[4:2]]);
    end
  end

  // Zero-wait answer in the access phase; writes complete and store nothing
  // Low and high words are separate reads, so a carry between them can tear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !pwrite && !apb_hit;
      prdata_q <= (apb_setup && !pwrite) ? apb_word : 32'h0000_0000;
    end
  end

  assign sysreg_rsp = rsp_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Checks
  sequence apb_wr_setup_s;
    psel && !penable && pwrite;
  endsequence

  sequence apb_wr_done_s;
    pready && !pslverr;
  endsequence

  core_cycles_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(cnt_load && sel == 5'h00) |=> cnt_q[0] == $past(cnt_q[0]) + 64'h1)
    else $error("core cycle counter missed a cycle");

  // Watches the retired counter, one of the counters a level 3 write can park at its maximum
  wrap_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cnt_q[2] == '1 && !(cnt_load && sel == 5'h02))
    |=> cnt_q[2] == W'($past(retired_count)) - 64'h1)
    else $error("counter did not wrap through zero");

  retired_add_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(cnt_load && sel == 5'h02) |=> cnt_q[2] == $past(cnt_q[2]) + W'($past(retired_count)))
    else $error("retired counter wrong increment");

  stall_add_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_stall_cycle && !(cnt_load && sel == 5'h03)) |=> cnt_q[3] == $past(cnt_q[3]) + 64'h1)
    else $error("memory stall not counted");

  low_write_trap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sysreg_req.valid && sysreg_req.write && is_cnt && below3) |=> (rsp_q.done && rsp_q.trap))
    else $error("counter write below level 3 not trapped");

  level2_trap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sysreg_req.valid && (is_cnt || is_type) && below2 && !level2_trap_en_q) |=> rsp_q.trap)
    else $error("level 2 trap enable ignored");

  type_fixed_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sysreg_req.valid && !sysreg_req.write && is_type && !trap && type_idx == 5'h03)
    |=> rsp_q.rdata == 64'h0000_0000_0000_4005)
    else $error("event type readback not fixed");

  apb_write_inert_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (apb_wr_setup_s and !sysreg_req.valid) |=> apb_wr_done_s ##0 ($stable(level2_trap_en_q)
    && $stable(level3_trap_en_q)))
    else $error("debug write not inert");

  apb_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (psel && !penable && !pwrite && paddr == 12'h400) |=> (pready && prdata == 32'h0000_0011))
    else $error("debug read of event type wrong");

endmodule : activity_monitor_counters

`default_nettype wire

// >>> hdl/activity_monitor_pkg.sv
// Shared constants and carriers of the activity monitor counters
package activity_monitor_pkg;

  localparam int unsigned NUM_CNT = 7;
  localparam int unsigned NUM_GRP0 = 4;
  localparam int unsigned NUM_GRP1 = 3;
  localparam int unsigned CNT_W = 64;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned ADDR_W = 12;

  // Counter slots; group 1 counters 10 to 12 live in slots 4 to 6
  localparam logic [2:0] SLOT_CORE_CYC = 3'h0;
  localparam logic [2:0] SLOT_CONST_CYC = 3'h1;
  localparam logic [2:0] SLOT_RETIRED = 3'h2;
  localparam logic [2:0] SLOT_MEM_STALL = 3'h3;

  // Fixed event codes, one per slot, slot 0 in the low half-word
  localparam logic [NUM_CNT-1:0][15:0] EVENT_CODE = {
    16'h0302, 16'h0301, 16'h0300, 16'h4005, 16'h0008, 16'h4004, 16'h0011
  };

  // System-register selector map
  localparam logic [SEL_W-1:0] SEL_CNT_BASE = 5'h00;
  localparam logic [SEL_W-1:0] SEL_TYPE_BASE = 5'h08;
  localparam logic [SEL_W-1:0] SEL_LEVEL2_AUX = 5'h10;
  localparam logic [SEL_W-1:0] SEL_LEVEL3_AUX = 5'h11;

  // Trap enable bit position in both auxiliary control registers
  localparam int unsigned TRAP_EN_BIT = 30;
  localparam logic TRAP_EN_RESET = 1'b0;

  // Privilege levels
  localparam logic [1:0] LEVEL2 = 2'h2;
  localparam logic [1:0] LEVEL3 = 2'h3;

  // Debug APB byte map: counters as low then high word, types one word each
  localparam logic [ADDR_W-1:0] APB_CNT_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] APB_CNT_SPAN = 12'h038;
  localparam logic [ADDR_W-1:0] APB_TYPE_BASE = 12'h400;
  localparam logic [ADDR_W-1:0] APB_TYPE_SPAN = 12'h01c;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] level;
    logic [SEL_W-1:0] sel;
    logic [CNT_W-1:0] wdata;
  } sysreg_req_t;

  typedef struct packed {
    logic done;
    logic trap;
    logic [CNT_W-1:0] rdata;
  } sysreg_rsp_t;

endpackage : activity_monitor_pkg

// >>> testbench/apb_master_model.sv
// Debug APB master model for the read-only port
`timescale 1ns/1ps
`default_nettype none
module apb_master_model (
  // Clock and slave answer
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Master request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, output logic [31:0] d,
                      output logic e);
    int k;
    @(negedge ref_clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    @(negedge ref_clk);
    penable = 1'b1;
    @(posedge ref_clk);
    // Bounded wait so a dead slave cannot hang the run
    for (k = 0; k < 8 && pready !== 1'b1; k++) @(posedge ref_clk);
    // Zero-wait slave: a late or missing ready poisons both results
    d = (k == 0 && pready === 1'b1) ? prdata : 32'hxxxx_xxxx;
    e = (k == 0 && pready === 1'b1) ? pslverr : 1'bx;
    @(negedge ref_clk);
    psel = 1'b0;
    penable = 1'b0;
    // Released address shows its inverse, never a stale match
    paddr = ~a;
  endtask : xfer
endmodule : apb_master_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the activity monitor counters
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic const_rate_tick = 1'b0;
  logic [2:0] retired_count = 3'h0;
  logic mem_stall_cycle = 1'b0;
  logic [2:0] aux_event = 3'h0;
  activity_monitor_pkg::sysreg_req_t sysreg_req = '0;
  activity_monitor_pkg::sysreg_rsp_t sysreg_rsp;
  logic psel, penable, pwrite, pready, pslverr, ae, tr;
  logic [11:0] paddr;
  logic [31:0] prdata, ad;
  logic [63:0] rd, v0;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tk, t0;
  always #2.5 ref_clk = ~ref_clk;
  activity_monitor_counters #(.RETIRE_W(3)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .const_rate_tick(const_rate_tick), .retired_count(retired_count),
    .mem_stall_cycle(mem_stall_cycle), .aux_event(aux_event), .sysreg_req(sysreg_req),
    .sysreg_rsp(sysreg_rsp), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  apb_master_model apb_u (.ref_clk(ref_clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr));
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic sr(input logic w, input logic [1:0] lv, input logic [4:0] s,
                    input logic [63:0] wd);
    @(negedge ref_clk);
    `CHK("done pulse", 1'b0, sysreg_rsp.done)
    sysreg_req = '{1'b1, w, lv, s, wd};
    @(posedge ref_clk);
    #1;
    tk = cyc;
    @(negedge ref_clk);
    sysreg_req.valid = 1'b0;
    rd = sysreg_rsp.rdata;
    tr = sysreg_rsp.trap;
    `CHK("done", 1'b1, sysreg_rsp.done)
  endtask : sr
  task automatic ev(input logic t, input logic [2:0] r, input logic m, input logic [2:0] x,
                    input int n);
    @(negedge ref_clk);
    {const_rate_tick, retired_count, mem_stall_cycle, aux_event} = {t, r, m, x};
    repeat (n) @(negedge ref_clk);
    {const_rate_tick, retired_count, mem_stall_cycle, aux_event} = 8'h00;
  endtask : ev
  task automatic t_events();
    logic [63:0] e[7] = '{64'h0, 64'h6, 64'h1b, 64'h5, 64'h2, 64'h1, 64'h4};
    `CHK("rsp", 66'h0, sysreg_rsp)
    ev(1'b1, 3'h5, 1'b1, 3'h4, 4);
    ev(1'b1, 3'h0, 1'b0, 3'h1, 2);
    ev(1'b0, 3'h7, 1'b1, 3'h2, 1);
    for (int i = 1; i < 7; i++) begin
      sr(1'b0, 2'h3, 5'(i), 64'h0);
      `CHK("counter", e[i], rd)
    end
    sr(1'b0, 2'h3, 5'h00, 64'h0);
    v0 = rd;
    t0 = tk;
    sr(1'b0, 2'h3, 5'h00, 64'h0);
    `CHK("cycles", 64'(tk - t0), rd - v0)
  endtask : t_events
  task automatic t_wrap_types();
    sr(1'b1, 2'h3, 5'h02, 64'hffff_ffff_ffff_ffff);
    ev(1'b0, 3'h2, 1'b0, 3'h0, 1);
    sr(1'b0, 2'h3, 5'h02, 64'h0);
    `CHK("wrap", 64'h1, rd)
    sr(1'b1, 2'h3, 5'h09, 64'h0);
    `CHK("type write trap", 1'b0, tr)
    for (int i = 0; i < 7; i++) begin
      sr(1'b0, 2'h3, 5'h08 + 5'(i), 64'h0);
      `CHK("type", {48'h0, activity_monitor_pkg::EVENT_CODE[i]}, rd)
    end
  endtask : t_wrap_types
  task automatic t_trap();
    sr(1'b0, 2'h1, 5'h01, 64'h0);
    `CHK("low trap", 1'b1, tr)
    `CHK("trap data", 64'h0, rd)
    sr(1'b0, 2'h2, 5'h01, 64'h0);
    `CHK("l2 trap", 1'b1, tr)
    sr(1'b1, 2'h3, 5'h11, 64'h0000_0000_4000_0000);
    sr(1'b0, 2'h2, 5'h01, 64'h0);
    `CHK("l2 open", 1'b0, tr)
    sr(1'b0, 2'h1, 5'h01, 64'h0);
    `CHK("l1 still", 1'b1, tr)
    sr(1'b1, 2'h2, 5'h10, 64'hffff_ffff_ffff_ffff);
    sr(1'b0, 2'h3, 5'h10, 64'h0);
    `CHK("aux bit", 64'h0000_0000_4000_0000, rd)
    sr(1'b0, 2'h1, 5'h01, 64'h0);
    `CHK("l1 read", 64'h6, rd)
    sr(1'b1, 2'h2, 5'h02, 64'h0000_0000_0000_0009);
    `CHK("write trap", 1'b1, tr)
    sr(1'b0, 2'h3, 5'h02, 64'h0);
    `CHK("kept", 64'h1, rd)
    sr(1'b0, 2'h3, 5'h07, 64'h0);
    `CHK("unmapped", 1'b1, tr)
  endtask : t_trap
  task automatic t_apb();
    apb_u.xfer(1'b0, 12'h010, ad, ae);
    `CHK("apb low", 32'h1, ad)
    apb_u.xfer(1'b0, 12'h014, ad, ae);
    `CHK("apb high", 32'h0, ad)
    for (int i = 0; i < 7; i++) begin
      apb_u.xfer(1'b0, 12'h400 + 12'(4 * i), ad, ae);
      `CHK("apb type", {16'h0, activity_monitor_pkg::EVENT_CODE[i]}, ad)
    end
    apb_u.xfer(1'b1, 12'h010, ad, ae);
    `CHK("apb wr err", 1'b0, ae)
    apb_u.xfer(1'b0, 12'h010, ad, ae);
    `CHK("apb after wr", 32'h1, ad)
    apb_u.xfer(1'b0, 12'h800, ad, ae);
    `CHK("apb unmapped", 1'b1, ae)
  endtask : t_apb
  task automatic t_reset();
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("rsp in reset", 66'h0, sysreg_rsp)
    rst_b = 1'b1;
    sr(1'b0, 2'h3, 5'h02, 64'h0);
    `CHK("cleared", 64'h0, rd)
    sr(1'b0, 2'h2, 5'h01, 64'h0);
    `CHK("trap again", 1'b1, tr)
  endtask : t_reset
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    t_events();
    t_wrap_types();
    t_trap();
    t_apb();
    t_reset();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
